// ### fsl_suspend_lock_ctl.sv
// Purpose: host-side sequencer for flash suspend and lock-bit commands
// Assumes: one flash on an asynchronous parallel bus
// Notes:   software orders ops through four registers
// Notes on behaviour
// - while suspended, only read array elsewhere, read status, resume.
// - lock set is setup write then block or permanent confirm write.
// - after lock set, check write/set error and clear status if set.
// - never run lock ops with protect pin between levels.
// - after clear lock-bits, check clear error and clear status.
// - an aborted clear leaves bits unknown; repeat the clear.
// - error bits clear only by the clear status command.
// - status bits 6 to 0 mean nothing while ready bit is zero.
//
// Local design decisions: the register offsets and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
`include "fsl_cfg.svh"
module fsl_suspend_lock_ctl
  import fsl_pkg::*;
#(
  parameter int HV_CYC    = `FSL_HV_CYC,
  parameter int MAX_RETRY = `FSL_MAX_RETRY
) (
  input  wire logic               CORE_CLK,
  input  wire logic               RST_N,
  input  wire logic [7:0]         REG_ADDR,
  input  wire logic [31:0]        REG_WDATA,
  input  wire logic               REG_WR,
  input  wire logic               REG_RD,
  output logic [31:0]             REG_RDATA,
  output logic [`FSL_AW-1:0]      FL_ADDR,
  output logic [`FSL_DW-1:0]      FL_DQ_O,
  input  wire logic [`FSL_DW-1:0] FL_DQ_I,
  output logic                    FL_DQ_OE_N,
  output logic                    FL_CE_N,
  output logic                    FL_WE_N,
  output logic                    FL_OE_N,
  input  wire logic               FL_READY_BUSY,
  output logic                    FL_PROTECT_HV
);
  fsl_state_e         state_r;
  fsl_op_e            op_r;
  fsl_cyc_s           cyc_r;
  logic               start_r;
  logic               pend_r;
  logic [`FSL_AW-1:0] addr_r;
  logic [`FSL_AW-1:0] susp_addr_r;
  logic               suspended_r;
  logic               refused_r;
  logic               err_r;
  logic [7:0]         sr_r;
  logic [`FSL_DW-1:0] data_r;
  logic [1:0]         retry_r;
  logic [11:0]        hv_cnt_r;
  logic               rb_s1_r;
  logic               rb_s2_r;
  logic               bus_done;
  logic [`FSL_DW-1:0] bus_rdata;
  logic               go;
  fsl_op_e            op_in;

  assign go    = REG_WR && (REG_ADDR == `FSL_REG_CTRL);
  assign op_in = fsl_op_e'(REG_WDATA[2:0]);

  // ****************************************
  // decoding helpers
  // ****************************************
  function automatic logic is_lock(input fsl_op_e op);
    is_lock = (op == OP_SET_BLK) || (op == OP_SET_PERM) ||
              (op == OP_CLR_LOCK);
  endfunction : is_lock

  function automatic logic susp_ok(input fsl_op_e op,
                                   input logic [`FSL_AW-1:0] a);
    susp_ok = (op == OP_RD_STAT) || (op == OP_RESUME) ||
              ((op == OP_RD_ARRAY) && (a != susp_addr_r));
  endfunction : susp_ok

  function automatic logic [7:0] cmd1(input fsl_op_e op);
    unique case (op)
      OP_RD_ARRAY: cmd1 = `FSL_CMD_RD_ARRAY;
      OP_RD_STAT:  cmd1 = `FSL_CMD_RD_STAT;
      OP_CLR_STAT: cmd1 = `FSL_CMD_CLR_STAT;
      OP_SUSPEND:  cmd1 = `FSL_CMD_SUSPEND;
      OP_RESUME:   cmd1 = `FSL_CMD_RESUME;
      default:     cmd1 = `FSL_CMD_LK_SETUP;
    endcase
  endfunction : cmd1

  function automatic logic [7:0] cmd2(input fsl_op_e op);
    unique case (op)
      OP_SET_BLK:  cmd2 = `FSL_CMD_BLK_CONF;
      OP_SET_PERM: cmd2 = `FSL_CMD_PERM_CONF;
      default:     cmd2 = `FSL_CMD_CLR_CONF;
    endcase
  endfunction : cmd2

  // failure of a finished lock op as the status byte reports it
  function automatic logic lock_err(input fsl_op_e op,
                                    input logic [7:0] sr);
    lock_err = (op == OP_CLR_LOCK) ?
      (sr[`FSL_SR_ECLR] | sr[`FSL_SR_SUPPLY] | sr[`FSL_SR_PROT]) :
      (sr[`FSL_SR_WSET] | sr[`FSL_SR_SUPPLY] | sr[`FSL_SR_PROT]);
  endfunction : lock_err

  // ****************************************
  // ready/busy pin synchroniser
  // ****************************************
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      rb_s1_r <= 1'b0;
      rb_s2_r <= 1'b0;
    end else begin
      rb_s1_r <= FL_READY_BUSY;
      rb_s2_r <= rb_s1_r;
    end
  end

  // address register
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      addr_r <= '0;
    end else if (REG_WR && (REG_ADDR == `FSL_REG_ADDR)) begin
      addr_r <= REG_WDATA[`FSL_AW-1:0];
    end
  end

  // ****************************************
  // command sequencer
  // ****************************************
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_r     <= ST_IDLE;
      op_r        <= OP_RD_STAT;
      cyc_r       <= '0;
      start_r     <= 1'b0;
      pend_r      <= 1'b0;
      susp_addr_r <= '0;
      suspended_r <= 1'b0;
      refused_r   <= 1'b0;
      err_r       <= 1'b0;
      sr_r        <= `FSL_SR_RST;
      data_r      <= '0;
      retry_r     <= 2'h0;
      hv_cnt_r    <= 12'h000;
      FL_PROTECT_HV <= 1'b0;
    end else begin
      start_r <= 1'b0;
      if (go && (state_r != ST_IDLE)) begin
        refused_r <= 1'b1;  // busy: order dropped
      end
      unique case (state_r)
        ST_IDLE: begin
          FL_PROTECT_HV <= 1'b0;
          if (go) begin
            if (suspended_r && !susp_ok(op_in, addr_r)) begin
              refused_r <= 1'b1;
            end else begin
              op_r      <= op_in;
              refused_r <= 1'b0;
              err_r     <= 1'b0;
              retry_r   <= 2'h0;
              if (op_in == OP_SUSPEND) begin
                susp_addr_r <= addr_r;
              end
              if (is_lock(op_in)) begin
                FL_PROTECT_HV <= 1'b1;
                hv_cnt_r      <= 12'(HV_CYC);
                state_r       <= ST_HV;
              end else begin
                state_r <= ST_W1;
              end
            end
          end
        end
        ST_HV: begin
          // settle the protect pin fully before any lock write
          if (hv_cnt_r == 12'h000) begin
            state_r <= ST_W1;
          end else begin
            hv_cnt_r <= hv_cnt_r - 12'h001;
          end
        end
        ST_W1: begin
          if (!pend_r) begin
            start_r <= 1'b1;
            pend_r  <= 1'b1;
            cyc_r   <= '{wr: 1'b1, addr: addr_r, data: {8'h00, cmd1(op_r)}};
          end else if (bus_done) begin
            pend_r <= 1'b0;
            if (is_lock(op_r)) begin
              state_r <= ST_W2;
            end else if (op_r == OP_RD_ARRAY) begin
              state_r <= ST_RD;
            end else if (op_r == OP_RESUME) begin
              suspended_r <= 1'b0;
              state_r     <= ST_IDLE;
            end else if (op_r == OP_CLR_STAT) begin
              sr_r    <= `FSL_SR_RST;
              state_r <= ST_IDLE;
            end else begin
              state_r <= ST_POLL;
            end
          end
        end
        ST_W2: begin
          if (!pend_r) begin
            start_r <= 1'b1;
            pend_r  <= 1'b1;
            cyc_r   <= '{wr: 1'b1, addr: addr_r, data: {8'h00, cmd2(op_r)}};
          end else if (bus_done) begin
            pend_r  <= 1'b0;
            state_r <= ST_POLL;
          end
        end
        ST_POLL: begin
          if (!pend_r && (rb_s2_r || (op_r == OP_RD_STAT))) begin
            start_r <= 1'b1;
            pend_r  <= 1'b1;
            cyc_r   <= '{wr: 1'b0, addr: addr_r, data: '0};
          end else if (pend_r && bus_done) begin
            pend_r <= 1'b0;
            // low bits are kept once the ready bit is one, or at once for a read status op
            if (bus_rdata[`FSL_SR_READY] || (op_r == OP_RD_STAT)) begin
              sr_r    <= bus_rdata[7:0];
              state_r <= ST_CHK;
            end
          end
        end
        ST_CHK: begin
          if (op_r == OP_SUSPEND) begin
            suspended_r <= sr_r[`FSL_SR_WSUSP];
          end
          if (is_lock(op_r) && lock_err(op_r, sr_r)) begin
            err_r   <= 1'b1;
            state_r <= ST_CLR;
          end else begin
            state_r <= ST_IDLE;
          end
        end
        ST_CLR: begin
          if (!pend_r) begin
            start_r <= 1'b1;
            pend_r  <= 1'b1;
            cyc_r   <= '{wr: 1'b1, addr: addr_r,
                         data: {8'h00, `FSL_CMD_CLR_STAT}};
          end else if (bus_done) begin
            pend_r <= 1'b0;
            if ((op_r == OP_CLR_LOCK) && (retry_r < 2'(MAX_RETRY))) begin
              retry_r <= retry_r + 2'h1;
              state_r <= ST_W1;
            end else begin
              state_r <= ST_IDLE;
            end
          end
        end
        ST_RD: begin
          if (!pend_r) begin
            start_r <= 1'b1;
            pend_r  <= 1'b1;
            cyc_r   <= '{wr: 1'b0, addr: addr_r, data: '0};
          end else if (bus_done) begin
            pend_r  <= 1'b0;
            data_r  <= bus_rdata;
            state_r <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // register read port, data one cycle after the strobe
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      REG_RDATA <= 32'h0000_0000;
    end else begin
      REG_RDATA <= 32'h0000_0000;
      if (REG_RD) begin
        unique case (REG_ADDR)
          `FSL_REG_CTRL: REG_RDATA <= {29'h0, op_r};
          `FSL_REG_ADDR: REG_RDATA <= {13'h0, addr_r};
          `FSL_REG_STAT: REG_RDATA <= {18'h0, retry_r, refused_r, err_r,
                                       suspended_r,
                                       state_r != ST_IDLE, sr_r};
          `FSL_REG_DATA: REG_RDATA <= {16'h0, data_r};
          default:       REG_RDATA <= 32'h0000_0000;
        endcase
      end
    end
  end

  fsl_bus_cycle u_bus (
    .clk        (CORE_CLK),
    .rst_n      (RST_N),
    .start      (start_r),
    .cyc        (cyc_r),
    .done       (bus_done),
    .rdata      (bus_rdata),
    .fl_addr    (FL_ADDR),
    .fl_dq_o    (FL_DQ_O),
    .fl_dq_i    (FL_DQ_I),
    .fl_dq_oe_n (FL_DQ_OE_N),
    .fl_ce_n    (FL_CE_N),
    .fl_we_n    (FL_WE_N),
    .fl_oe_n    (FL_OE_N)
  );

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);

  sequence s_w1_lock_done;
    (state_r == ST_W1) && pend_r && bus_done && is_lock(op_r);
  endsequence
  sequence s_clr_retry;
    (state_r == ST_CLR) && pend_r && bus_done &&
    (op_r == OP_CLR_LOCK) && (retry_r < 2'(MAX_RETRY));
  endsequence

  property p_susp_refuse;
    (state_r == ST_IDLE) && go && suspended_r && !susp_ok(op_in, addr_r)
      |=> (state_r == ST_IDLE) && refused_r;
  endproperty
  a_susp_refuse: assert property (p_susp_refuse)
    else $error("illegal order taken while suspended");

  property p_lock_confirm;
    s_w1_lock_done |=> (state_r == ST_W2)
      ##1 (start_r && cyc_r.wr && (cyc_r.data[7:0] == cmd2(op_r)));
  endproperty
  a_lock_confirm: assert property (p_lock_confirm)
    else $error("lock setup not followed by confirm write");

  property p_set_err_clear;
    (state_r == ST_CHK) && ((op_r == OP_SET_BLK) ||
      (op_r == OP_SET_PERM)) && sr_r[`FSL_SR_WSET] |=> state_r == ST_CLR;
  endproperty
  a_set_err_clear: assert property (p_set_err_clear)
    else $error("set error not followed by status clear");

  property p_hv_before_lock;
    start_r && cyc_r.wr && is_lock(op_r)
      |-> FL_PROTECT_HV && (hv_cnt_r == 12'h000);
  endproperty
  a_hv_before_lock: assert property (p_hv_before_lock)
    else $error("lock write before protect level settled");

  property p_clr_err_clear;
    (state_r == ST_CHK) && (op_r == OP_CLR_LOCK) && sr_r[`FSL_SR_ECLR]
      |=> state_r == ST_CLR;
  endproperty
  a_clr_err_clear: assert property (p_clr_err_clear)
    else $error("clear error not followed by status clear");

  property p_clr_retry;
    s_clr_retry |=> (state_r == ST_W1) && FL_PROTECT_HV
      ##1 (start_r && (cyc_r.data[7:0] == `FSL_CMD_LK_SETUP));
  endproperty
  a_clr_retry: assert property (p_clr_retry)
    else $error("failed clear of lock-bits not repeated");

  property p_clr_stat_only;
    start_r && cyc_r.wr && (cyc_r.data[7:0] == `FSL_CMD_CLR_STAT)
      |-> (state_r == ST_CLR) || (op_r == OP_CLR_STAT);
  endproperty
  a_clr_stat_only: assert property (p_clr_stat_only)
    else $error("status clear written out of place");

  property p_busy_status_ignored;
    (state_r == ST_POLL) && pend_r && bus_done && (op_r != OP_RD_STAT) &&
      !bus_rdata[`FSL_SR_READY] |=> (state_r == ST_POLL) && $stable(sr_r);
  endproperty
  a_busy_status_ignored: assert property (p_busy_status_ignored)
    else $error("status kept while flash busy");
endmodule : fsl_suspend_lock_ctl
`default_nettype wire

// ### fsl_cfg.svh
// Purpose: constants of the flash suspend and lock-bit controller
// Assumes: 100 MHz core clock
// Notes:   offsets, status bit positions, command codes and timing
`ifndef FSL_CFG_SVH
`define FSL_CFG_SVH
// ****************************************
// widths
// ****************************************
`define FSL_AW          19
`define FSL_DW          16
// ****************************************
// register offsets of the command port
// ****************************************
`define FSL_REG_CTRL    8'h00
`define FSL_REG_ADDR    8'h04
`define FSL_REG_STAT    8'h08
`define FSL_REG_DATA    8'h0C
// ****************************************
// flash status bit positions
// ****************************************
`define FSL_SR_READY    7
`define FSL_SR_ECLR     5
`define FSL_SR_WSET     4
`define FSL_SR_SUPPLY   3
`define FSL_SR_WSUSP    2
`define FSL_SR_PROT     1
`define FSL_SR_RST      8'h00
// ****************************************
// flash command codes
// ****************************************
`define FSL_CMD_RD_ARRAY  8'hFF
`define FSL_CMD_RD_STAT   8'h70
`define FSL_CMD_CLR_STAT  8'h50
`define FSL_CMD_SUSPEND   8'h5B
`define FSL_CMD_RESUME    8'hD0
`define FSL_CMD_LK_SETUP  8'h60
`define FSL_CMD_BLK_CONF  8'h01
`define FSL_CMD_PERM_CONF 8'hF1
`define FSL_CMD_CLR_CONF  8'hD0
// ****************************************
// timing
// ****************************************
`define FSL_CLK_NS      10
`define FSL_T_WP_NS     50
`define FSL_T_ACC_NS    100
`define FSL_T_HV_NS     2000
`define FSL_WP_CYC  ((`FSL_T_WP_NS + `FSL_CLK_NS - 1) / `FSL_CLK_NS)
`define FSL_ACC_CYC ((`FSL_T_ACC_NS + `FSL_CLK_NS - 1) / `FSL_CLK_NS)
`define FSL_HV_CYC  ((`FSL_T_HV_NS + `FSL_CLK_NS - 1) / `FSL_CLK_NS)
`define FSL_MAX_RETRY   1
`endif

// ### fsl_pkg.sv
// Purpose: types of the flash suspend and lock-bit controller
// Assumes: fsl_cfg.svh on the include path
// Notes:   ops, sequencer states, bus phases, cycle request
`include "fsl_cfg.svh"
package fsl_pkg;
  typedef enum logic [2:0] {
    OP_RD_ARRAY = 3'h0, OP_RD_STAT = 3'h1, OP_CLR_STAT = 3'h2,
    OP_SUSPEND  = 3'h3, OP_RESUME  = 3'h4, OP_SET_BLK  = 3'h5,
    OP_SET_PERM = 3'h6, OP_CLR_LOCK = 3'h7
  } fsl_op_e;
  typedef enum logic [7:0] {
    ST_IDLE = 8'h01, ST_HV  = 8'h02, ST_W1  = 8'h04, ST_W2 = 8'h08,
    ST_POLL = 8'h10, ST_CHK = 8'h20, ST_CLR = 8'h40, ST_RD = 8'h80
  } fsl_state_e;
  typedef enum logic [3:0] {
    PH_IDLE = 4'h1, PH_SETUP = 4'h2, PH_STRB = 4'h4, PH_END = 4'h8
  } fsl_phase_e;
  typedef struct packed {
    logic                wr;
    logic [`FSL_AW-1:0]  addr;
    logic [`FSL_DW-1:0]  data;
  } fsl_cyc_s;
endpackage : fsl_pkg

// ### fsl_bus_cycle.sv
// Purpose: one asynchronous flash bus cycle, write or read
// Assumes: flash data input is asynchronous to the core clock
// Notes:   address and chip select lead the strobe by one cycle
`timescale 1ns/10ps
`default_nettype none
`include "fsl_cfg.svh"
module fsl_bus_cycle
  import fsl_pkg::*;
#(
  parameter int WP_CYC  = `FSL_WP_CYC,
  parameter int ACC_CYC = `FSL_ACC_CYC
) (
  input  wire logic               clk,
  input  wire logic               rst_n,
  input  wire logic               start,
  input  wire fsl_cyc_s           cyc,
  output logic                    done,
  output logic [`FSL_DW-1:0]      rdata,
  output logic [`FSL_AW-1:0]      fl_addr,
  output logic [`FSL_DW-1:0]      fl_dq_o,
  input  wire logic [`FSL_DW-1:0] fl_dq_i,
  output logic                    fl_dq_oe_n,
  output logic                    fl_ce_n,
  output logic                    fl_we_n,
  output logic                    fl_oe_n
);
  fsl_phase_e         ph_r;
  logic [7:0]         cnt_r;
  logic               wr_r;
  logic [`FSL_DW-1:0] dq_s1_r;
  logic [`FSL_DW-1:0] dq_s2_r;

  // two-stage synchroniser on the data pins
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dq_s1_r <= '0;
      dq_s2_r <= '0;
    end else begin
      dq_s1_r <= fl_dq_i;
      dq_s2_r <= dq_s1_r;
    end
  end

  // cycle phases; read strobe is stretched by the sync latency
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ph_r       <= PH_IDLE;
      cnt_r      <= 8'h00;
      wr_r       <= 1'b0;
      done       <= 1'b0;
      rdata      <= '0;
      fl_addr    <= '0;
      fl_dq_o    <= '0;
      fl_dq_oe_n <= 1'b1;
      fl_ce_n    <= 1'b1;
      fl_we_n    <= 1'b1;
      fl_oe_n    <= 1'b1;
    end else begin
      done <= 1'b0;
      unique case (ph_r)
        PH_IDLE: if (start) begin
          fl_addr    <= cyc.addr;
          fl_dq_o    <= cyc.data;
          fl_dq_oe_n <= ~cyc.wr;  // low while driving
          fl_ce_n    <= 1'b0;
          wr_r       <= cyc.wr;
          ph_r       <= PH_SETUP;
        end
        PH_SETUP: begin
          fl_we_n <= ~wr_r;
          fl_oe_n <= wr_r;
          cnt_r   <= wr_r ? 8'(WP_CYC) : 8'(ACC_CYC + 2);
          ph_r    <= PH_STRB;
        end
        PH_STRB: begin
          if (cnt_r == 8'h01) begin
            fl_we_n <= 1'b1;
            fl_oe_n <= 1'b1;
            rdata   <= dq_s2_r;
            ph_r    <= PH_END;
          end else begin
            cnt_r <= cnt_r - 8'h01;
          end
        end
        PH_END: begin
          fl_ce_n    <= 1'b1;
          fl_dq_oe_n <= 1'b1;
          done       <= 1'b1;
          ph_r       <= PH_IDLE;
        end
      endcase
    end
  end
endmodule : fsl_bus_cycle
`default_nettype wire

// ### fsl_flash_model.sv
// Purpose: behavioural flash device with word write suspend and lock-bits
// Assumes: one command is taken per rising write enable with chip enabled
// Notes:   knobs let the bench fake a low supply or a weak protect pin
`timescale 1ns/10ps
`default_nettype none
`include "fsl_cfg.svh"
module fsl_flash_model
  import fsl_pkg::*;
(
  input  wire logic               clk,
  input  wire logic [`FSL_AW-1:0] addr,
  input  wire logic [`FSL_DW-1:0] dq_o,
  input  wire logic               ce_n,
  input  wire logic               we_n,
  input  wire logic               oe_n,
  input  wire logic               prot_hv,
  input  wire logic               vpp_low,
  input  wire logic               hv_fail,
  input  wire logic               wip,
  output logic [`FSL_DW-1:0]      dq_i,
  output logic                    ready_busy
);
  logic [7:0]  sr = 8'h80;
  logic [7:0]  nsr = 8'h80;
  logic [15:0] blk = '0;
  logic [15:0] last = '0;
  logic        perm = 0, pend = 0, rsm = 0, susp = 0, we_q = 1;
  int          busy = 0;
  wire         hv_ok = prot_hv && !hv_fail;
  // a write can only be running where the lock state lets it
  wire         wr_ok = !blk[addr[18:15]] || (hv_ok && !perm);
  // ready pin follows the ready bit
  assign ready_busy = sr[7];
  // a released bus shows the inverse of the last value, not a stale copy
  always_comb begin
    if (!ce_n && !oe_n) dq_i = rsm ? {8'h00, sr} : addr[15:0] ^ 16'hA5C3;
    else dq_i = ~last;
  end
  // ****************************************
  // command decode and internal timing
  // ****************************************
  task automatic run(input logic [7:0] c);
    rsm = 1;
    if (pend) begin
      pend = 0;
      nsr = sr | 8'h80;
      sr[7] = 0;
      busy = 20;
      if (vpp_low && c == 8'hD0) nsr |= 8'h28;
      else if (c == 8'h01) begin
        if (perm || !hv_ok) nsr |= 8'h12;
        else blk[addr[18:15]] = 1;
      end else if (c == 8'hF1) begin
        if (!hv_ok) nsr |= 8'h12;
        else perm = 1;
      end else if (c == 8'hD0) begin
        if (perm || !hv_ok) nsr |= 8'h22;
        else blk = '0;
      end else nsr |= 8'h30;
    end else case (c)
      8'h60: pend = 1;
      8'h50: if (!susp) sr[5:1] &= 5'b00010;
      8'hFF: rsm = 0;
      8'h5B: if (wip && wr_ok && !susp) begin
        susp = 1;
        sr[7] = 0;
        nsr = sr | 8'h84;
        busy = 6;
      end
      8'hD0: if (susp) begin
        susp = 0;
        sr[7] = 0;
        sr[2] = 0;
        nsr = sr | 8'h80;
        busy = 30;
      end
      default: ;
    endcase
  endtask : run
  // pins sampled and state moved on the falling edge, clear of the
  // controller's own edge, so its flops never race the model
  always @(negedge clk) begin
    if (!ce_n && !oe_n) last = dq_i;
    if (busy > 0) begin
      busy--;
      if (busy == 0) sr = nsr;
    end
    if (!ce_n && we_n && !we_q) run(dq_o[7:0]);
    we_q = we_n;
  end
endmodule : fsl_flash_model
`default_nettype wire

// ### testbench.sv
// Purpose: self-checking bench of the suspend and lock-bit controller
// Assumes: short high-voltage settle count for a quick run
// Notes:   expected status bytes come from a small lock model here
`timescale 1ns/10ps
`default_nettype none
`include "fsl_cfg.svh"
module testbench;
  import fsl_pkg::*;
  logic               clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0;
  logic [7:0]         reg_addr = 0;
  logic [31:0]        reg_wdata = 0, reg_rdata, s;
  logic [`FSL_AW-1:0] fl_addr, a, b;
  logic [`FSL_DW-1:0] fl_dq_o, fl_dq_i;
  logic               fl_dq_oe_n, fl_ce_n, fl_we_n, fl_oe_n, fl_rb, fl_hv;
  logic               vpp_low = 0, hv_fail = 0, wip = 0;
  int                 failures = 0, checks = 0, cyc = 0, perm_m = 0;
  initial forever #5 clk = ~clk;
  fsl_suspend_lock_ctl #(.HV_CYC(2), .MAX_RETRY(1)) i_fsl_suspend_lock_ctl (
    .CORE_CLK(clk), .RST_N(rst_n), .REG_ADDR(reg_addr),
    .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd),
    .REG_RDATA(reg_rdata), .FL_ADDR(fl_addr), .FL_DQ_O(fl_dq_o),
    .FL_DQ_I(fl_dq_i), .FL_DQ_OE_N(fl_dq_oe_n), .FL_CE_N(fl_ce_n),
    .FL_WE_N(fl_we_n), .FL_OE_N(fl_oe_n), .FL_READY_BUSY(fl_rb),
    .FL_PROTECT_HV(fl_hv));
  fsl_flash_model i_fsl_flash_model (
    .clk(clk), .addr(fl_addr), .dq_o(fl_dq_o), .ce_n(fl_ce_n),
    .we_n(fl_we_n), .oe_n(fl_oe_n), .prot_hv(fl_hv), .vpp_low(vpp_low),
    .hv_fail(hv_fail), .wip(wip), .dq_i(fl_dq_i), .ready_busy(fl_rb));
  // ****************************************
  // register bus tasks and checks
  // ****************************************
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= ad;
    reg_wdata <= d;
    reg_wr <= 1;
    @(posedge clk);
    reg_wr <= 0;
  endtask : wr
  task automatic rd(input logic [7:0] ad, output logic [31:0] d);
    @(posedge clk);
    reg_addr <= ad;
    reg_rd <= 1;
    @(posedge clk);
    reg_rd <= 0;
    #1 d = reg_rdata;
  endtask : rd
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED t=%0t got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic complete_run;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : complete_run
  // start one op and poll the busy flag under a bound
  task automatic op_run(input logic [2:0] op, input logic [18:0] ad);
    wr(8'h04, {13'h0, ad});
    wr(8'h00, {29'h0, op});
    for (int i = 0; i < 3000; i++) begin
      rd(8'h08, s);
      if (!s[8]) break;
    end
    chk(s[8], 0);
  endtask : op_run
  // reference status byte of a lock op: 5 block, 6 permanent, 7 clear
  function automatic logic [7:0] exp_sr(input int op);
    if (op == 7 && vpp_low) return 8'hA8;
    if (hv_fail || (perm_m != 0 && op != 6)) return op == 7 ? 8'hA2 : 8'h92;
    if (op == 6) perm_m = 1;
    return 8'h80;
  endfunction : exp_sr
  task automatic lk(input int op);
    logic [7:0] e;
    a = 19'($urandom);
    e = exp_sr(op);
    op_run(3'(op), a);
    chk(s[7:0], e);
    chk(s[10], e != 8'h80);
    chk(fl_hv, 0);
  endtask : lk
  // cut a hang short
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      failures++;
      complete_run();
    end
  end
  // data pins driven under a write strobe, released under a read strobe
  always @(negedge clk) begin
    if (!fl_we_n) chk(fl_dq_oe_n, 0);
    if (!fl_oe_n) chk(fl_dq_oe_n, 1);
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    void'($urandom(32'hE949CC7B));
    repeat (16) @(posedge clk);
    rst_n <= 1;
    rd(8'h08, s);
    chk(s, 0);
    rd(8'h10, s);
    chk(s, 0);
    $display("test reset done");
    lk(5);
    chk(i_fsl_flash_model.blk[a[18:15]], 1);
    lk(7);
    chk(i_fsl_flash_model.blk, 0);
    vpp_low = 1;
    lk(7);
    chk(s[13:12], 2'h1);
    vpp_low = 0;
    hv_fail = 1;
    lk(5);
    lk(6);
    lk(7);
    hv_fail = 0;
    $display("test lock done");
    wip = 1;
    op_run(3'd3, a);
    chk(s[9:0], 10'h284);
    op_run(3'd2, a);
    chk(s[11], 1);
    op_run(3'd0, a ^ 19'h08000);
    rd(8'h0C, s);
    chk(s[15:0], (a[15:0] ^ 16'h8000) ^ 16'hA5C3);
    op_run(3'd0, a);
    chk(s[11], 1);
    op_run(3'd4, a);
    chk(s[9], 0);
    wip = 0;
    $display("test suspend done");
    lk(5);
    b = a;
    lk(6);
    wip = 1;
    op_run(3'd3, b);
    chk(s[9:0], 10'h080);
    wip = 0;
    lk(5);
    lk(7);
    op_run(3'd1, a);
    chk(s[7:0], 8'h80);
    op_run(3'd2, a);
    chk(s[7:0], 8'h00);
    $display("test permanent done");
    complete_run();
  end
endmodule : testbench
`default_nettype wire
